/* hdl/nibble_out_pkg.sv */
// Package with constants and types for the nibble fabric output block.
package nibble_out_pkg;
   localparam int SLICES = 6;
   localparam int WORD_W = 8;
   localparam int CFG_W = 16;
   localparam int CFG_A_W = 8;
   localparam logic [1:0] RESET_SYNC = 2'h0;
   localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
   localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
   localparam logic [CFG_A_W-1:0] ADDR_RESET = 8'h00;
   localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
   localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
   // Cycles the tracking logic waits after enable before it reports ready.
   localparam logic [3:0] TRACK_SETTLE = 4'h8;
   localparam logic [3:0] TRACK_COUNT_RESET = 4'h0;

   typedef enum logic [2:0]
   {
      TRACK_IDLE = 3'b001,
      TRACK_SETTLING = 3'b010,
      TRACK_READY = 3'b100
   } track_state_type;
endpackage

/* hdl/rx_slice_word.sv */
// One slice receive path: deserialiser with FIFO or bypass output selection.
`timescale 1ns/1ps
`default_nettype none
module rx_slice_word
   import nibble_out_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Serial input and mode.
   input wire logic serial_in,
   input wire logic use_fifo,
   input wire logic fifo_rd_en,
   // Word output.
   output logic [WORD_W-1:0] word
);
   typedef struct packed
   {
      logic [WORD_W-1:0] shift;
      logic [2:0] count;
      logic [WORD_W-1:0] held;
      logic held_full;
      logic [WORD_W-1:0] word;
   } slice_state_type;

   slice_state_type state;
   slice_state_type next_state;

   // Shift in one bit per cycle; a full word either goes straight out or waits in a
   // one-entry FIFO until the fabric reads it or the next full word overwrites it.
   always_comb
   begin
      next_state = state;
      next_state.shift = {state.shift[WORD_W-2:0], serial_in};
      next_state.count = state.count + 3'h1;
      if (use_fifo && fifo_rd_en && state.held_full)
      begin
         next_state.word = state.held;
         next_state.held_full = 1'b0;
      end
      if (state.count == BIT_COUNT_LAST)
      begin
         if (use_fifo)
         begin
            next_state.held = {state.shift[WORD_W-2:0], serial_in};
            next_state.held_full = 1'b1;
         end
         else
         begin
            next_state.word = {state.shift[WORD_W-2:0], serial_in};
         end
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '{WORD_RESET, BIT_COUNT_RESET, WORD_RESET, 1'b0, WORD_RESET};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign word = state.word;
endmodule // rx_slice_word
`default_nettype wire

/* hdl/nibble_fabric_out.sv */
// Fabric-facing output side of one I/O nibble: tracking, receive words, config bus, tristate.
//
// Function
// - Tracking ready first rises only while the fabric holds tracking enable high.
// - Once ready has risen it stays high when tracking enable drops.
// - Reasserting tracking enable after a drop lowers ready, then raises it again.
// - Six 8-bit receive words, each built from the same-index slice serial input.
// - Each word comes from the FIFO or the bypass; FIFO words follow reads.
// - Sixteen-bit config bus read data is returned on the control clock.
// - Owner valid is high whenever the fabric owns the config bus.
// - Calibration engine writes win over fabric writes.
// - On collision valid drops and the fabric write presented in the same cycle is retained.
// - After calibration writes end valid rises and the retained write executes.
// - Fabric writes presented while valid is low are discarded.
// - Direct select passes the slice tristate input straight through.
// - Write-enable select drives the inverted serialised write enable on tristate output.
`timescale 1ns/1ps
`default_nettype none
module nibble_fabric_out
   import nibble_out_pkg::*;
(
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RESET_N,
   // Tracking handshake.
   input wire logic TRACKING_ENABLE,
   output logic TRACKING_READY,
   // Receive slices.
   input wire logic [SLICES-1:0] SLICE_SERIAL_INPUT,
   input wire logic [SLICES-1:0] FIFO_MODE_SELECT,
   input wire logic [SLICES-1:0] FIFO_READ_ENABLE,
   output logic [WORD_W-1:0] RX_WORD_0,
   output logic [WORD_W-1:0] RX_WORD_1,
   output logic [WORD_W-1:0] RX_WORD_2,
   output logic [WORD_W-1:0] RX_WORD_3,
   output logic [WORD_W-1:0] RX_WORD_4,
   output logic [WORD_W-1:0] RX_WORD_5,
   // Fabric side of the config bus.
   input wire logic FABRIC_WRITE,
   input wire logic [CFG_A_W-1:0] FABRIC_ADDR,
   input wire logic [CFG_W-1:0] FABRIC_WDATA,
   input wire logic [CFG_W-1:0] CONFIG_BUS_RDATA_IN,
   // Calibration engine side of the config bus.
   input wire logic CAL_WRITE,
   input wire logic [CFG_A_W-1:0] CAL_ADDR,
   input wire logic [CFG_W-1:0] CAL_WDATA,
   // Write port towards the configuration storage.
   output logic CONFIG_WRITE,
   output logic [CFG_A_W-1:0] CONFIG_ADDR,
   output logic [CFG_W-1:0] CONFIG_WDATA,
   output logic [CFG_W-1:0] CONFIG_BUS_READ_WORD,
   output logic CONFIG_BUS_OWNER_VALID,
   // Tristate control.
   input wire logic [SLICES-1:0] TRISTATE_SOURCE_SELECT,
   input wire logic [SLICES-1:0] TRISTATE_IN,
   input wire logic WRITE_ENABLE_IN,
   output logic [SLICES-1:0] TRISTATE_OUT
);
   typedef struct packed
   {
      track_state_type track;
      logic [3:0] settle;
      logic enable_seen;
      logic valid;
      logic pend;
      logic [CFG_A_W-1:0] pend_addr;
      logic [CFG_W-1:0] pend_data;
      logic cfg_write;
      logic [CFG_A_W-1:0] cfg_addr;
      logic [CFG_W-1:0] cfg_data;
      logic [CFG_W-1:0] rdata;
      logic wren_q;
   } top_state_type;

   top_state_type state;
   top_state_type next_state;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [WORD_W-1:0] words [SLICES];

   // Reset release through two flops so every register on rst_n leaves reset on the same edge.
   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rst_sync <= RESET_SYNC;
      end
      else
      begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // One deserialiser per slice, each fed by its own serial input.
   genvar gi;
   generate
      for (gi = 0; gi < SLICES; gi++)
      begin : g_slice
         rx_slice_word u_slice
         (
            .clk(MCLK),
            .rst_n(rst_n),
            .serial_in(SLICE_SERIAL_INPUT[gi]),
            .use_fifo(FIFO_MODE_SELECT[gi]),
            .fifo_rd_en(FIFO_READ_ENABLE[gi]),
            .word(words[gi])
         );
      end
   endgenerate

   // Tracking handshake, config bus arbitration and write-enable serialisation.
   always_comb
   begin
      next_state = state;
      next_state.enable_seen = TRACKING_ENABLE;
      case (state.track)
         TRACK_IDLE:
         begin
            next_state.settle = TRACK_COUNT_RESET;
            if (TRACKING_ENABLE)
            begin
               next_state.track = TRACK_SETTLING;
            end
         end
         TRACK_SETTLING:
         begin
            // Settling restarts if the enable falls; ready needs a held enable.
            if (!TRACKING_ENABLE)
            begin
               next_state.track = TRACK_IDLE;
            end
            else if (state.settle == TRACK_SETTLE - 4'h1)
            begin
               next_state.track = TRACK_READY;
            end
            else
            begin
               next_state.settle = state.settle + 4'h1;
            end
         end
         TRACK_READY:
         begin
            // Ready holds through a low enable and drops on its next rise.
            if (TRACKING_ENABLE && !state.enable_seen)
            begin
               next_state.track = TRACK_SETTLING;
               next_state.settle = TRACK_COUNT_RESET;
            end
            else
            begin
               next_state.track = TRACK_READY;
            end
         end
         default:
         begin
            next_state.track = TRACK_IDLE;
         end
      endcase

      // Calibration first, then a retained write, then a granted fabric write; a fabric
      // write seen while valid is low reaches none of the branches and is lost.
      next_state.cfg_write = 1'b0;
      next_state.rdata = CONFIG_BUS_RDATA_IN;
      if (CAL_WRITE)
      begin
         next_state.cfg_write = 1'b1;
         next_state.cfg_addr = CAL_ADDR;
         next_state.cfg_data = CAL_WDATA;
         next_state.valid = 1'b0;
         if (state.valid && FABRIC_WRITE)
         begin
            next_state.pend = 1'b1;
            next_state.pend_addr = FABRIC_ADDR;
            next_state.pend_data = FABRIC_WDATA;
         end
      end
      else if (!state.valid)
      begin
         next_state.valid = 1'b1;
         if (state.pend)
         begin
            next_state.cfg_write = 1'b1;
            next_state.cfg_addr = state.pend_addr;
            next_state.cfg_data = state.pend_data;
            next_state.pend = 1'b0;
         end
      end
      else if (FABRIC_WRITE)
      begin
         next_state.cfg_write = 1'b1;
         next_state.cfg_addr = FABRIC_ADDR;
         next_state.cfg_data = FABRIC_WDATA;
      end
      next_state.wren_q = WRITE_ENABLE_IN;
   end

   // State register.
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '{TRACK_IDLE, TRACK_COUNT_RESET, 1'b0, 1'b1, 1'b0, ADDR_RESET, CFG_RESET,
            1'b0, ADDR_RESET, CFG_RESET, CFG_RESET, 1'b0};
      end
      else
      begin
         state <= next_state;
      end
   end

   // Per-slice tristate source; the write enable path is registered to align with TX data.
   always_comb
   begin
      for (int i = 0; i < SLICES; i++)
      begin
         TRISTATE_OUT[i] = TRISTATE_SOURCE_SELECT[i] ? !state.wren_q : TRISTATE_IN[i];
      end
   end

   assign TRACKING_READY = (state.track == TRACK_READY);
   assign CONFIG_BUS_OWNER_VALID = state.valid;
   assign CONFIG_BUS_READ_WORD = state.rdata;
   assign CONFIG_WRITE = state.cfg_write;
   assign CONFIG_ADDR = state.cfg_addr;
   assign CONFIG_WDATA = state.cfg_data;
   assign RX_WORD_0 = words[0];
   assign RX_WORD_1 = words[1];
   assign RX_WORD_2 = words[2];
   assign RX_WORD_3 = words[3];
   assign RX_WORD_4 = words[4];
   assign RX_WORD_5 = words[5];

   // Checks on the handshakes, the read word and the tristate outputs.
   sequence s_collide;
      CAL_WRITE && CONFIG_BUS_OWNER_VALID && FABRIC_WRITE;
   endsequence
   sequence s_cal_done;
      !CAL_WRITE && !CONFIG_BUS_OWNER_VALID;
   endsequence
   sequence s_cal_hold;
      CAL_WRITE && !CONFIG_BUS_OWNER_VALID;
   endsequence
   a_ready_needs_enable: assert property (@(posedge MCLK) disable iff (!rst_n)
      $rose(TRACKING_READY) |-> $past(TRACKING_ENABLE)) else $error("ready rose without enable");
   a_ready_holds: assert property (@(posedge MCLK) disable iff (!rst_n)
      TRACKING_READY && !TRACKING_ENABLE |=> TRACKING_READY) else $error("ready dropped");
   a_ready_reenable: assert property (@(posedge MCLK) disable iff (!rst_n)
      TRACKING_READY && $rose(TRACKING_ENABLE) |=> !TRACKING_READY) else $error("ready held");
   a_cal_wins: assert property (@(posedge MCLK) disable iff (!rst_n)
      CAL_WRITE |=> CONFIG_WRITE && CONFIG_ADDR == $past(CAL_ADDR)) else $error("cal lost");
   a_collide_drop: assert property (@(posedge MCLK) disable iff (!rst_n)
      CAL_WRITE |=> !CONFIG_BUS_OWNER_VALID) else $error("valid stayed high");
   a_retained_write: assert property (@(posedge MCLK) disable iff (!rst_n)
      s_collide ##1 s_cal_done |=> CONFIG_WRITE && CONFIG_BUS_OWNER_VALID
         && CONFIG_ADDR == $past(FABRIC_ADDR, 2)) else $error("retained write lost");
   a_retained_late: assert property (@(posedge MCLK) disable iff (!rst_n)
      s_collide ##1 s_cal_hold ##1 s_cal_done |=> CONFIG_WRITE && CONFIG_BUS_OWNER_VALID
         && CONFIG_ADDR == $past(FABRIC_ADDR, 3)) else $error("late retained write lost");
   a_discard_low: assert property (@(posedge MCLK) disable iff (!rst_n)
      !CONFIG_BUS_OWNER_VALID && !state.pend && !CAL_WRITE |=> !CONFIG_WRITE)
      else $error("write while low");
   a_read_word: assert property (@(posedge MCLK) disable iff (!rst_n)
      1'b1 |=> CONFIG_BUS_READ_WORD == $past(CONFIG_BUS_RDATA_IN)) else $error("read word");
   a_tristate_direct: assert property (@(posedge MCLK) disable iff (!rst_n)
      !TRISTATE_SOURCE_SELECT[0] |-> TRISTATE_OUT[0] == TRISTATE_IN[0]) else $error("tristate");
   a_tristate_wren: assert property (@(posedge MCLK) disable iff (!rst_n)
      TRISTATE_SOURCE_SELECT[5] |-> TRISTATE_OUT[5] == !$past(WRITE_ENABLE_IN))
      else $error("tristate write enable");
endmodule // nibble_fabric_out
`default_nettype wire

/* dv/fabric_user_model.sv */
// Fabric user logic model that issues config bus writes.
`timescale 1ns/1ps
`default_nettype none
module fabric_user_model
   import nibble_out_pkg::*;
(
   // Clock and bus ownership.
   input wire logic clk,
   input wire logic owner_valid,
   // Commands from the bench.
   input wire logic cmd,
   input wire logic rude,
   input wire logic [CFG_A_W-1:0] cmd_addr,
   input wire logic [CFG_W-1:0] cmd_data,
   // Write request towards the block.
   output logic wr,
   output logic [CFG_A_W-1:0] addr,
   output logic [CFG_W-1:0] data
);
   logic go;
   logic pushy;
   logic [CFG_A_W-1:0] held_addr;
   logic [CFG_W-1:0] held_data;
   // A command is captured on the edge and shown one step later, only while the block
   // grants the bus in that cycle; rude mode ignores the grant to test discarding.
   always @(posedge clk)
   begin
      go = cmd;
      pushy = rude;
      held_addr = cmd_addr;
      held_data = cmd_data;
      #1;
      wr = go && (owner_valid || pushy);
      // Idle lines toggle so a stale value is never mistaken for data.
      addr = wr ? held_addr : ~addr;
      data = wr ? held_data : ~data;
   end
   initial
   begin
      wr = 1'b0;
      addr = ADDR_RESET;
      data = CFG_RESET;
   end
endmodule // fabric_user_model
`default_nettype wire

/* dv/tb_nibble_fabric_out.sv */
// Self-checking bench for the nibble fabric output block.
`timescale 1ns/1ps
`default_nettype none
module tb_nibble_fabric_out;
   import nibble_out_pkg::*;
   logic MCLK = 1'b0;
   logic RESET_N = 1'b0;
   logic en = 1'b0, we = 1'b0, cmd = 1'b0, rude = 1'b0, cal = 1'b0;
   logic [SLICES-1:0] ser = 6'h00, rd = 6'h00, tsel = 6'h30, tin = 6'h00;
   logic [CFG_A_W-1:0] cmd_addr = 8'h00, cal_addr = 8'h00;
   logic [CFG_W-1:0] cmd_data = 16'h0000, cal_data = 16'h0000, rdin = 16'h0000;
   logic [7:0] b;
   wire logic ready, fwr, cwr, valid;
   wire logic [CFG_A_W-1:0] faddr, caddr;
   wire logic [CFG_W-1:0] fdata, cdata, rword;
   wire logic [SLICES-1:0] tout;
   wire logic [WORD_W-1:0] rxw [SLICES];
   int fail_count = 0, n_compared = 0, ecnt = 0, j;

   nibble_fabric_out nibble_fabric_out_i (.MCLK(MCLK), .RESET_N(RESET_N),
      .TRACKING_ENABLE(en), .TRACKING_READY(ready), .SLICE_SERIAL_INPUT(ser),
      .FIFO_MODE_SELECT(6'h20), .FIFO_READ_ENABLE(rd), .RX_WORD_0(rxw[0]),
      .RX_WORD_1(rxw[1]), .RX_WORD_2(rxw[2]), .RX_WORD_3(rxw[3]), .RX_WORD_4(rxw[4]),
      .RX_WORD_5(rxw[5]), .FABRIC_WRITE(fwr), .FABRIC_ADDR(faddr), .FABRIC_WDATA(fdata),
      .CONFIG_BUS_RDATA_IN(rdin), .CAL_WRITE(cal), .CAL_ADDR(cal_addr),
      .CAL_WDATA(cal_data), .CONFIG_WRITE(cwr), .CONFIG_ADDR(caddr),
      .CONFIG_WDATA(cdata), .CONFIG_BUS_READ_WORD(rword), .CONFIG_BUS_OWNER_VALID(valid),
      .TRISTATE_SOURCE_SELECT(tsel), .TRISTATE_IN(tin), .WRITE_ENABLE_IN(we),
      .TRISTATE_OUT(tout));
   fabric_user_model fabric_user_model_i (.clk(MCLK), .owner_valid(valid), .cmd(cmd),
      .rude(rude), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .wr(fwr), .addr(faddr),
      .data(fdata));

   // Free-running clock.
   always #10 MCLK = ~MCLK;

   function automatic logic [7:0] pat(input int i, input int n);
      pat = 8'((i + 1) * 37 + n * 29);
   endfunction

   // One bit per slice per cycle, MSB first, framed from the third edge after release.
   always @(posedge MCLK)
   begin
      if (RESET_N)
         ecnt++;
      #1;
      for (int i = 0; i < SLICES; i++)
      begin
         b = pat(i, (ecnt - 2) / 8);
         ser[i] <= (ecnt >= 2) ? b[7 - (ecnt - 2) % 8] : 1'b0;
      end
   end

   task automatic step(input int n = 1);
      repeat (n) @(posedge MCLK);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Bounded wait, since the settle time is the designer's choice.
   task automatic wait_ready();
      for (int k = 0; k < 12 && ready !== 1'b1; k++)
         step();
      chk(ready, 1'b1);
   endtask

   // Step until the bit phase is mid-word, so word boundaries never race a check.
   task automatic align(input int ph);
      while ((ecnt - 11) % 8 != ph)
         step();
   endtask

   task automatic fab(input logic [7:0] a, input logic [15:0] d, input logic r);
      cmd_addr = a;
      cmd_data = d;
      rude = r;
      cmd = 1'b1;
      step();
      cmd = 1'b0;
   endtask

   // Watchdog far beyond the sixty or so cycles the sequence needs.
   initial
   begin
      #100000;
      fail_count++;
      conclude();
   end

   initial
   begin
      step(8);
      chk({ready, cwr, valid}, 3'h1);
      RESET_N = 1'b1;
      step(2);
      en = 1'b1;
      step();
      chk(ready, 1'b0);
      wait_ready();
      en = 1'b0;
      step(3);
      chk(ready, 1'b1);
      en = 1'b1;
      step();
      chk(ready, 1'b0);
      wait_ready();
      align(4);
      for (int i = 0; i < 5; i++)
         chk(rxw[i], pat(i, (ecnt - 11) / 8));
      chk(rxw[5], 8'h00);
      align(3);
      rd = 6'h20;
      step();
      rd = 6'h00;
      j = (ecnt - 11) / 8;
      step();
      chk(rxw[5], pat(5, j));
      step(8);
      chk(rxw[5], pat(5, j));
      rdin = 16'hBEEF;
      step();
      chk(rword, 16'hBEEF);
      fab(8'h11, 16'h1111, 1'b0);
      step();
      chk({cwr, caddr, cdata, valid}, {1'b1, 8'h11, 16'h1111, 1'b1});
      fab(8'h22, 16'h2222, 1'b0);
      cal = 1'b1;
      cal_addr = 8'hC1;
      cal_data = 16'hCA01;
      step();
      chk({cwr, caddr, cdata, valid}, {1'b1, 8'hC1, 16'hCA01, 1'b0});
      cal_data = 16'hCA02;
      fab(8'h33, 16'h3333, 1'b1);
      chk({cwr, caddr, cdata, valid}, {1'b1, 8'hC1, 16'hCA02, 1'b0});
      cal = 1'b0;
      step();
      chk({cwr, caddr, cdata, valid}, {1'b1, 8'h22, 16'h2222, 1'b1});
      step();
      chk(cwr, 1'b0);
      // A lone calibration write, then a rude write in the recovery cycle with nothing held.
      cal = 1'b1;
      fab(8'h44, 16'h4444, 1'b1);
      chk({cwr, caddr, valid}, {1'b1, 8'hC1, 1'b0});
      cal = 1'b0;
      step();
      chk({cwr, valid}, 2'h1);
      tin = 6'h3A;
      we = 1'b1;
      step();
      chk(tout, 6'h0A);
      we = 1'b0;
      tin = 6'h05;
      #1;
      chk(tout, 6'h05);
      step();
      chk(tout, 6'h35);
      conclude();
   end
endmodule // tb_nibble_fabric_out
`default_nettype wire
